/* File: bench/pin_board.sv */
// Board model for one 8-pin port: pad drivers, pull-ups and floating pins
`timescale 1ns/1ps
module pin_board (
   input  wire logic       aclk,
   input  wire logic [7:0] pad_out,
   input  wire logic [7:0] pad_oe,
   input  wire logic [7:0] pullup_en,
   input  wire logic [7:0] ext_val,
   input  wire logic [7:0] ext_en,
   output logic      [7:0] pad_level
);
   logic [7:0] float_q = 8'h00;

   // Floating pins change every cycle so a stale value is never mistaken for a level
   always_ff @(posedge aclk) begin
      float_q <= ~float_q;
   end

   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (pad_oe[i]) begin
            pad_level[i] = pad_out[i];
         end else if (ext_en[i]) begin
            pad_level[i] = ext_val[i];
         end else if (pullup_en[i]) begin
            pad_level[i] = 1'b1;
         end else begin
            pad_level[i] = float_q[i];
         end
      end
   end
endmodule : pin_board

/* File: bench/port_pin_control_pullup_sva.sv */
// Port-level assertions for the pin control block
`timescale 1ns/1ps
module port_pin_control_pullup_sva #(
   parameter int ADDR_W = 12
) (
   input wire logic              aclk,
   input wire logic              aresetn,
   input wire logic              s_axi_awvalid,
   input wire logic              s_axi_awready,
   input wire logic              s_axi_wvalid,
   input wire logic              s_axi_wready,
   input wire logic [1:0]        s_axi_bresp,
   input wire logic              s_axi_bvalid,
   input wire logic              s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic              s_axi_arvalid,
   input wire logic              s_axi_arready,
   input wire logic [31:0]       s_axi_rdata,
   input wire logic [1:0]        s_axi_rresp,
   input wire logic              s_axi_rvalid,
   input wire logic              s_axi_rready,
   input wire logic [7:0]        port1_dir_out,
   input wire logic [7:0]        port1_pad_out,
   input wire logic [7:0]        port1_pad_oe,
   input wire logic [7:0]        port1_pullup_en,
   input wire logic [7:0]        port2_out_data,
   input wire logic [7:0]        port2_pad_out,
   input wire logic [7:0]        port2_pad_oe,
   input wire logic [7:0]        port2_pullup_en,
   input wire logic              analog_in_ch9,
   input wire logic              analog_in_ch12
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_p1_reset_vals: assert property ($rose(aresetn) |-> port1_pad_out == 8'hf8
      && port1_pullup_en == 8'h00 && port2_pullup_en == 8'h00) else $error("reset values off");
   a_p2_reset_od: assert property ($rose(aresetn) |-> port2_pad_out == 8'h00
      && port2_pad_oe == ~port2_out_data && !analog_in_ch9 && !analog_in_ch12) else $error("port 2 reset mode off");
   a_p1_oe_dir: assert property (port1_pad_oe == port1_dir_out) else $error("port 1 enable off");
   a_p2_drive_data: assert property ((port2_pad_oe & (port2_pad_out ^ port2_out_data)) == 8'h00)
      else $error("port 2 drives against data");
   a_analog_no_drive: assert property ((analog_in_ch9 |-> !port2_pad_oe[0])
      and (analog_in_ch12 |-> !port2_pad_oe[7])) else $error("analog pin driven");
   a_read_one_cycle: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
      && s_axi_rdata[31:8] == 24'h0) else $error("read answer late or wide");
   a_read_p1_out: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h304
      && port1_dir_out == 8'hff |=> s_axi_rdata[7:0] == $past(port1_pad_out)) else $error("port 1 readback off");
   a_read_pullup: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h358
      |=> s_axi_rdata[7:0] == $past(port1_pullup_en) && s_axi_rresp == 2'h0) else $error("pull-up readback off");
   a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   a_bresp_cause: assert property ($rose(s_axi_bvalid) |-> $past(s_axi_awvalid && s_axi_awready
      || s_axi_wvalid && s_axi_wready)) else $error("write answer without request");

   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_read: cover property (s_axi_rvalid && s_axi_rready);
   c_analog: cover property (analog_in_ch9 && analog_in_ch12);
endmodule : port_pin_control_pullup_sva

bind port_pin_control_pullup port_pin_control_pullup_sva #(.ADDR_W(ADDR_W)) sva_i (.aclk, .aresetn, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port1_dir_out,
   .port1_pad_out, .port1_pad_oe, .port1_pullup_en, .port2_out_data, .port2_pad_out, .port2_pad_oe,
   .port2_pullup_en, .analog_in_ch9, .analog_in_ch12);

/* File: bench/test_port_pin_control_pullup.sv */
// Self-checking bench for the port pin control block
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("wrong value at %0t: got %0h expected %0h", $time, (g), (e)); end end
module test_port_pin_control_pullup;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'h0;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [7:0]  port1_dir_out = 8'hff, port2_out_data = 8'h5a, p1_ext_val = 8'h00, p1_ext_en = 8'h00;
   logic [7:0]  port1_pad_in, port1_pad_out, port1_pad_oe, port1_pullup_en;
   logic [7:0]  port2_pad_in, port2_pad_out, port2_pad_oe, port2_pin_level, port2_pullup_en;
   logic        analog_in_ch9, analog_in_ch10, analog_in_ch11, analog_in_ch12;
   int          error_cnt = 0, num_checks = 0;

   always #2 aclk = ~aclk;

   port_pin_control_pullup #(.ADDR_W(12)) port_pin_control_pullup_i (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .port1_dir_out, .port1_pad_in, .port1_pad_out, .port1_pad_oe, .port1_pullup_en, .port2_out_data,
      .port2_pad_in, .port2_pad_out, .port2_pad_oe, .port2_pin_level, .port2_pullup_en, .analog_in_ch9,
      .analog_in_ch10, .analog_in_ch11, .analog_in_ch12);
   pin_board board1_i (.aclk, .pad_out(port1_pad_out), .pad_oe(port1_pad_oe), .pullup_en(port1_pullup_en),
      .ext_val(p1_ext_val), .ext_en(p1_ext_en), .pad_level(port1_pad_in));
   pin_board board2_i (.aclk, .pad_out(port2_pad_out), .pad_oe(port2_pad_oe), .pullup_en(port2_pullup_en),
      .ext_val(8'h00), .ext_en(8'h00), .pad_level(port2_pad_in));

   task automatic complete_run();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : complete_run

   // Handshakes are judged at the falling edge, released by the following rising edge
   task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] er);
      logic ha, hw, hb;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int n = 0; n < 50; n++) begin
         @(negedge aclk);
         ha = s_axi_awvalid && s_axi_awready;
         hw = s_axi_wvalid && s_axi_wready;
         hb = s_axi_bvalid;
         if (hb) `CHK(s_axi_bresp, er)
         @(posedge aclk);
         if (ha) s_axi_awvalid <= 1'b0;
         if (hw) s_axi_wvalid <= 1'b0;
         if (hb) begin
            s_axi_bready <= 1'b0;
            return;
         end
      end
      error_cnt++;
      complete_run();
   endtask : wr

   task automatic chk_rd(input logic [11:0] a, input logic [7:0] ed, input logic [1:0] er);
      logic hs;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int n = 0; n < 50; n++) begin
         @(negedge aclk);
         hs = s_axi_arvalid && s_axi_arready;
         if (s_axi_rvalid) begin
            `CHK(s_axi_rdata, {24'h0, ed})
            `CHK(s_axi_rresp, er)
            @(posedge aclk);
            s_axi_rready <= 1'b0;
            return;
         end
         @(posedge aclk);
         if (hs) s_axi_arvalid <= 1'b0;
      end
      error_cnt++;
      complete_run();
   endtask : chk_rd

   task automatic t_reset();
      chk_rd(12'h304, 8'hf8, 2'h0);
      chk_rd(12'h358, 8'h00, 2'h0);
      chk_rd(12'h36c, 8'h00, 2'h0);
      chk_rd(12'h364, 8'h55, 2'h0);
      chk_rd(12'h368, 8'h55, 2'h0);
      chk_rd(12'h300, 8'h00, 2'h2);
      `CHK(port2_pad_oe, ~port2_out_data)
   endtask : t_reset

   task automatic t_pullup();
      wr(12'h358, 8'ha5, 4'hf, 2'h0);
      wr(12'h36c, 8'h3c, 4'hf, 2'h0);
      wr(12'h358, 8'hff, 4'h0, 2'h0);
      wr(12'h35c, 8'hff, 4'hf, 2'h2);
      chk_rd(12'h358, 8'ha5, 2'h0);
      `CHK(port1_pullup_en, 8'ha5)
      `CHK(port2_pullup_en, 8'h3c)
   endtask : t_pullup

   // Low nibble drives, high nibble listens to the board
   task automatic t_port1();
      @(posedge aclk);
      port1_dir_out <= 8'h0f;
      p1_ext_val <= 8'ha5;
      p1_ext_en <= 8'hf0;
      wr(12'h304, 8'h3c, 4'hf, 2'h0);
      repeat (4) @(posedge aclk);
      `CHK(port1_pad_out[3:0], 4'hc)
      chk_rd(12'h304, 8'hac, 2'h0);
   endtask : t_port1

   task automatic t_port2_modes();
      logic [7:0] hi [5] = '{8'h00, 8'h55, 8'haa, 8'hff, 8'he4};
      logic [7:0] lo [5] = '{8'h00, 8'h55, 8'haa, 8'hff, 8'h1b};
      logic [15:0] m;
      logic [1:0] c;
      logic [7:0] eo, ee;
      for (int k = 0; k < 5; k++) begin
         wr(12'h364, hi[k], 4'hf, 2'h0);
         wr(12'h368, lo[k], 4'hf, 2'h0);
         m = {hi[k], lo[k]};
         for (int i = 0; i < 8; i++) begin
            c = m[2*i +: 2];
            ee[i] = (c == 2'h3) || (c == 2'h1 && !port2_out_data[i]);
            eo[i] = (c == 2'h3) && port2_out_data[i];
         end
         @(negedge aclk);
         `CHK(port2_pad_oe, ee)
         `CHK(port2_pad_out, eo)
         // Selects only route; software enables the converter elsewhere
         `CHK({analog_in_ch12, analog_in_ch11, analog_in_ch10, analog_in_ch9},
              {m[15:14] == 2'h2, m[13:12] == 2'h2, m[11:10] == 2'h2, m[1:0] == 2'h2})
      end
   endtask : t_port2_modes

   // Open-drain pins written 1 float up to the pull-up, pins written 0 pull low
   task automatic t_od_level();
      wr(12'h364, 8'h55, 4'hf, 2'h0);
      wr(12'h368, 8'h55, 4'hf, 2'h0);
      wr(12'h36c, 8'hff, 4'hf, 2'h0);
      @(posedge aclk);
      port2_out_data <= 8'h0f;
      repeat (4) @(posedge aclk);
      `CHK(port2_pin_level, 8'h0f)
   endtask : t_od_level

   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_pullup();
      t_port1();
      t_port2_modes();
      t_od_level();
      repeat (4) @(posedge aclk);
      complete_run();
   end
endmodule : test_port_pin_control_pullup

/* File: rtl/gpio_defines.svh */
// Register indices, reset values, field codes and bus codes of the port block
`ifndef GPIO_DEFINES_SVH
`define GPIO_DEFINES_SVH

// Register indices; byte address is four times the index
`define IDX_PORT1_PIN_DATA      8'hc1
`define IDX_PORT1_PULLUP_ENABLE 8'hd6
`define IDX_PORT2_MODE_HIGH     8'hd9
`define IDX_PORT2_MODE_LOW      8'hda
`define IDX_PORT2_PULLUP_ENABLE 8'hdb

// Reset values
`define RST_PORT1_PIN_DATA      8'hf8
`define RST_PULLUP_ENABLE       8'h00
`define RST_PORT2_MODE          8'h55

// Pin mode codes
`define MODE_CODE_INPUT         2'h0
`define MODE_CODE_OPEN_DRAIN    2'h1
`define MODE_CODE_ANALOG        2'h2
`define MODE_CODE_PUSH_PULL     2'h3

// Width of one pin mode field and pins per mode register
`define MODE_FIELD_W            2
`define PINS_PER_MODE_REG       4

// Lowest port 2 pin with an analog alternate function above pin 0
`define FIRST_HIGH_ANALOG_PIN   5

// Word address split
`define WORD_LSB                2

// Response codes
`define RESP_OKAY               2'h0
`define RESP_SLVERR             2'h2

`endif

/* File: rtl/gpio_pkg.sv */
// Types and shared decode helpers of the port block
package gpio_pkg;

   typedef enum logic [1:0] {
      PIN_INPUT      = 2'h0,
      PIN_OPEN_DRAIN = 2'h1,
      PIN_ANALOG     = 2'h2,
      PIN_PUSH_PULL  = 2'h3
   } pin_mode_t;

   typedef enum logic [1:0] {
      WR_IDLE      = 2'h0,
      WR_HAVE_ADDR = 2'h1,
      WR_HAVE_DATA = 2'h2,
      WR_RESP      = 2'h3
   } wr_state_t;

   typedef enum logic [0:0] {
      RD_IDLE = 1'h0,
      RD_RESP = 1'h1
   } rd_state_t;

   // Analog code is only legal where the pin has an analog channel
   function automatic pin_mode_t legal_mode(input logic [1:0] code, input logic has_analog);
      pin_mode_t m;
      m = pin_mode_t'(code);
      if (m == PIN_ANALOG && !has_analog) begin
         m = PIN_INPUT;
      end
      return m;
   endfunction : legal_mode

endpackage : gpio_pkg

/* File: rtl/port2_pin_bank.sv */
// Port 2 pin drivers and analog selects decoded from the two mode registers
`timescale 1ns/1ps
`include "gpio_defines.svh"
module port2_pin_bank (
   input  wire logic [7:0] mode_high,
   input  wire logic [7:0] mode_low,
   input  wire logic [7:0] out_data,
   output logic      [7:0] pad_out,
   output logic      [7:0] pad_oe,
   output logic      [3:0] analog_sel
);
   import gpio_pkg::*;

   logic [15:0] modes;
   pin_mode_t   pm [8];

   assign modes = {mode_high, mode_low};

   always_comb begin
      for (int i = 0; i < 8; i++) begin
         pm[i] = legal_mode(modes[i*`MODE_FIELD_W +: `MODE_FIELD_W],
                            (i == 0) || (i >= `FIRST_HIGH_ANALOG_PIN));
         case (pm[i])
            PIN_OPEN_DRAIN: begin
               // Only ever pulls low; high comes from the pull-up or board
               pad_out[i] = 1'b0;
               pad_oe[i]  = ~out_data[i];
            end
            PIN_PUSH_PULL: begin
               pad_out[i] = out_data[i];
               pad_oe[i]  = 1'b1;
            end
            default: begin
               pad_out[i] = 1'b0;
               pad_oe[i]  = 1'b0;
            end
         endcase
      end
      // Channel 9 on pin 0, channels 10..12 on pins 5..7
      analog_sel[0] = (pm[0] == PIN_ANALOG);
      analog_sel[1] = (pm[5] == PIN_ANALOG);
      analog_sel[2] = (pm[6] == PIN_ANALOG);
      analog_sel[3] = (pm[7] == PIN_ANALOG);
   end
endmodule : port2_pin_bank

/* File: rtl/port_pin_control_pullup.sv */
// Port 1 and port 2 pin control with pull-up enables, reached over AXI4-Lite
// Functional notes
// - Port 1 pull-up bit per pin, reset zero
// - Port 2 pull-up bit per pin, reset zero
// - Port 1 input bits read pin level
// - Port 1 output pins drive data bit
// - Port 2 high mode register resets 0x55
// - Port 2 low mode register resets 0x55
// - Pins 7..1 modes; analog only pins 7..5
// - Pin 0 modes, code 10 is channel 9
// - Two-bit fields, high pin in top bits
`timescale 1ns/1ps
`include "gpio_defines.svh"
module port_pin_control_pullup #(
   parameter int ADDR_W = 12
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // AXI4-Lite write address
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]        s_axi_awprot,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]        s_axi_arprot,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Port 1 direction from its mode control, 1 = output
   input  wire logic [7:0]        port1_dir_out,
   // Port 1 pins
   input  wire logic [7:0]        port1_pad_in,
   output logic [7:0]             port1_pad_out,
   output logic [7:0]             port1_pad_oe,
   output logic [7:0]             port1_pullup_en,
   // Port 2 output data from its data register
   input  wire logic [7:0]        port2_out_data,
   // Port 2 pins
   input  wire logic [7:0]        port2_pad_in,
   output logic [7:0]             port2_pad_out,
   output logic [7:0]             port2_pad_oe,
   output logic [7:0]             port2_pin_level,
   output logic [7:0]             port2_pullup_en,
   // Analog alternate function selects
   output logic                   analog_in_ch9,
   output logic                   analog_in_ch10,
   output logic                   analog_in_ch11,
   output logic                   analog_in_ch12
);
   import gpio_pkg::*;

   localparam int IDX_W = ADDR_W - `WORD_LSB;

   // Register storage
   logic [7:0]      port1_pin_data_q;
   logic [7:0]      port1_pin_data_d;
   logic [7:0]      port1_pullup_enable_q;
   logic [7:0]      port1_pullup_enable_d;
   logic [7:0]      port2_mode_high_q;
   logic [7:0]      port2_mode_high_d;
   logic [7:0]      port2_mode_low_q;
   logic [7:0]      port2_mode_low_d;
   logic [7:0]      port2_pullup_enable_q;
   logic [7:0]      port2_pullup_enable_d;

   // Write channel state
   wr_state_t       wr_state_q;
   wr_state_t       wr_state_d;
   logic [IDX_W-1:0] wr_idx_q;
   logic [IDX_W-1:0] wr_idx_d;
   logic [7:0]      wr_data_q;
   logic [7:0]      wr_data_d;
   logic            wr_lane_q;
   logic            wr_lane_d;
   logic [1:0]      bresp_q;
   logic [1:0]      bresp_d;

   // Read channel state
   rd_state_t       rd_state_q;
   rd_state_t       rd_state_d;
   logic [31:0]     rdata_q;
   logic [31:0]     rdata_d;
   logic [1:0]      rresp_q;
   logic [1:0]      rresp_d;

   // Write commit helpers
   logic            aw_take;
   logic            w_take;
   logic            wr_commit;
   logic [IDX_W-1:0] commit_idx;
   logic [7:0]      commit_data;
   logic            commit_lane;

   // Synchronised port 1 pin level and decoded analog selects
   logic [7:0]      port1_level;
   logic [3:0]      analog_sel;

   // Is an index one of the five mapped registers
   function automatic logic idx_mapped(input logic [IDX_W-1:0] idx);
      return (idx == IDX_W'(`IDX_PORT1_PIN_DATA))
          || (idx == IDX_W'(`IDX_PORT1_PULLUP_ENABLE))
          || (idx == IDX_W'(`IDX_PORT2_MODE_HIGH))
          || (idx == IDX_W'(`IDX_PORT2_MODE_LOW))
          || (idx == IDX_W'(`IDX_PORT2_PULLUP_ENABLE));
   endfunction : idx_mapped

   // Port 1 readback: pin level where input, latch where output
   function automatic logic [7:0] port1_readback(input logic [7:0] level,
                                                 input logic [7:0] latch,
                                                 input logic [7:0] dir);
      return (level & ~dir) | (latch & dir);
   endfunction : port1_readback

   // Pin input synchronisers
   sync2 #(
      .WIDTH    (8)
   ) u_sync_port1 (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .async_in (port1_pad_in),
      .sync_out (port1_level)
   );

   sync2 #(
      .WIDTH    (8)
   ) u_sync_port2 (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .async_in (port2_pad_in),
      .sync_out (port2_pin_level)
   );

   // Write channel
   // Address and data may arrive in either order; the register
   // is written at the edge where the later of the two is taken.
   assign s_axi_awready = (wr_state_q == WR_IDLE) || (wr_state_q == WR_HAVE_DATA);
   assign s_axi_wready  = (wr_state_q == WR_IDLE) || (wr_state_q == WR_HAVE_ADDR);
   assign aw_take       = s_axi_awvalid && s_axi_awready;
   assign w_take        = s_axi_wvalid && s_axi_wready;

   always_comb begin
      wr_state_d  = wr_state_q;
      wr_idx_d    = wr_idx_q;
      wr_data_d   = wr_data_q;
      wr_lane_d   = wr_lane_q;
      bresp_d     = bresp_q;
      wr_commit   = 1'b0;
      commit_idx  = wr_idx_q;
      commit_data = wr_data_q;
      commit_lane = wr_lane_q;
      if (aw_take) begin
         wr_idx_d   = s_axi_awaddr[ADDR_W-1:`WORD_LSB];
         commit_idx = s_axi_awaddr[ADDR_W-1:`WORD_LSB];
      end
      if (w_take) begin
         wr_data_d   = s_axi_wdata[7:0];
         wr_lane_d   = s_axi_wstrb[0];
         commit_data = s_axi_wdata[7:0];
         commit_lane = s_axi_wstrb[0];
      end
      case (wr_state_q)
         WR_IDLE: begin
            if (aw_take && w_take) begin
               wr_commit = 1'b1;
            end else if (aw_take) begin
               wr_state_d = WR_HAVE_ADDR;
            end else if (w_take) begin
               wr_state_d = WR_HAVE_DATA;
            end
         end
         WR_HAVE_ADDR: begin
            wr_commit = w_take;
         end
         WR_HAVE_DATA: begin
            wr_commit = aw_take;
         end
         WR_RESP: begin
            if (s_axi_bready) begin
               wr_state_d = WR_IDLE;
            end
         end
         default: begin
            wr_state_d = WR_IDLE;
         end
      endcase
      if (wr_commit) begin
         wr_state_d = WR_RESP;
         bresp_d    = idx_mapped(commit_idx) ? `RESP_OKAY : `RESP_SLVERR;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state_q <= WR_IDLE;
         wr_idx_q   <= '0;
         wr_data_q  <= '0;
         wr_lane_q  <= 1'b0;
         bresp_q    <= `RESP_OKAY;
      end else begin
         wr_state_q <= wr_state_d;
         wr_idx_q   <= wr_idx_d;
         wr_data_q  <= wr_data_d;
         wr_lane_q  <= wr_lane_d;
         bresp_q    <= bresp_d;
      end
   end

   assign s_axi_bvalid = (wr_state_q == WR_RESP);
   assign s_axi_bresp  = bresp_q;

   // Register file; only byte lane 0 carries register bits
   always_comb begin
      port1_pin_data_d      = port1_pin_data_q;
      port1_pullup_enable_d = port1_pullup_enable_q;
      port2_mode_high_d     = port2_mode_high_q;
      port2_mode_low_d      = port2_mode_low_q;
      port2_pullup_enable_d = port2_pullup_enable_q;
      if (wr_commit && commit_lane) begin
         case (commit_idx)
            IDX_W'(`IDX_PORT1_PIN_DATA): begin
               // Latch is written even for input pins, driven once turned to output
               port1_pin_data_d = commit_data;
            end
            IDX_W'(`IDX_PORT1_PULLUP_ENABLE): begin
               port1_pullup_enable_d = commit_data;
            end
            IDX_W'(`IDX_PORT2_MODE_HIGH): begin
               port2_mode_high_d = commit_data;
            end
            IDX_W'(`IDX_PORT2_MODE_LOW): begin
               port2_mode_low_d = commit_data;
            end
            IDX_W'(`IDX_PORT2_PULLUP_ENABLE): begin
               port2_pullup_enable_d = commit_data;
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         port1_pin_data_q      <= `RST_PORT1_PIN_DATA;
         port1_pullup_enable_q <= `RST_PULLUP_ENABLE;
         port2_mode_high_q     <= `RST_PORT2_MODE;
         port2_mode_low_q      <= `RST_PORT2_MODE;
         port2_pullup_enable_q <= `RST_PULLUP_ENABLE;
      end else begin
         port1_pin_data_q      <= port1_pin_data_d;
         port1_pullup_enable_q <= port1_pullup_enable_d;
         port2_mode_high_q     <= port2_mode_high_d;
         port2_mode_low_q      <= port2_mode_low_d;
         port2_pullup_enable_q <= port2_pullup_enable_d;
      end
   end

   // Read channel; data is captured when the address is taken,
   // so a pin level is two synchroniser stages old at that edge.
   assign s_axi_arready = (rd_state_q == RD_IDLE);

   always_comb begin
      logic [IDX_W-1:0] ridx;
      ridx       = s_axi_araddr[ADDR_W-1:`WORD_LSB];
      rd_state_d = rd_state_q;
      rdata_d    = rdata_q;
      rresp_d    = rresp_q;
      case (rd_state_q)
         RD_IDLE: begin
            if (s_axi_arvalid) begin
               rd_state_d = RD_RESP;
               rresp_d    = idx_mapped(ridx) ? `RESP_OKAY : `RESP_SLVERR;
               rdata_d    = '0;
               case (ridx)
                  IDX_W'(`IDX_PORT1_PIN_DATA): begin
                     rdata_d[7:0] = port1_readback(port1_level, port1_pin_data_q,
                                                   port1_dir_out);
                  end
                  IDX_W'(`IDX_PORT1_PULLUP_ENABLE): begin
                     rdata_d[7:0] = port1_pullup_enable_q;
                  end
                  IDX_W'(`IDX_PORT2_MODE_HIGH): begin
                     rdata_d[7:0] = port2_mode_high_q;
                  end
                  IDX_W'(`IDX_PORT2_MODE_LOW): begin
                     rdata_d[7:0] = port2_mode_low_q;
                  end
                  IDX_W'(`IDX_PORT2_PULLUP_ENABLE): begin
                     rdata_d[7:0] = port2_pullup_enable_q;
                  end
                  default: begin
                  end
               endcase
            end
         end
         RD_RESP: begin
            if (s_axi_rready) begin
               rd_state_d = RD_IDLE;
            end
         end
         default: begin
            rd_state_d = RD_IDLE;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state_q <= RD_IDLE;
         rdata_q    <= '0;
         rresp_q    <= `RESP_OKAY;
      end else begin
         rd_state_q <= rd_state_d;
         rdata_q    <= rdata_d;
         rresp_q    <= rresp_d;
      end
   end

   assign s_axi_rvalid = (rd_state_q == RD_RESP);
   assign s_axi_rdata  = rdata_q;
   assign s_axi_rresp  = rresp_q;

   // Port 1 pins
   // Output style lives in the port 1 mode control, so output
   // pins are driven both ways here.
   assign port1_pad_out   = port1_pin_data_q;
   assign port1_pad_oe    = port1_dir_out;
   assign port1_pullup_en = port1_pullup_enable_q;

   // Port 2 pins
   // Selecting analog only routes the pin; the converter itself
   // must still be enabled in its own block.
   port2_pin_bank u_port2 (
      .mode_high  (port2_mode_high_q),
      .mode_low   (port2_mode_low_q),
      .out_data   (port2_out_data),
      .pad_out    (port2_pad_out),
      .pad_oe     (port2_pad_oe),
      .analog_sel (analog_sel)
   );

   assign port2_pullup_en = port2_pullup_enable_q;
   assign analog_in_ch9   = analog_sel[0];
   assign analog_in_ch10  = analog_sel[1];
   assign analog_in_ch11  = analog_sel[2];
   assign analog_in_ch12  = analog_sel[3];

endmodule : port_pin_control_pullup

/* File: rtl/sync2.sv */
// Two flip-flop synchroniser for pin levels
`timescale 1ns/1ps
module sync2 #(
   parameter int WIDTH = 8
) (
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;

   always_comb begin
      meta_d = async_in;
      sync_d = meta_q;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_out = sync_q;
endmodule : sync2
